// >>> pkg/sac_cfg.svh
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// Register byte offsets on the APB
`define SAC_OFF_SC1 8'h00
`define SAC_OFF_SC2 8'h04
`define SAC_OFF_RESH 8'h08
`define SAC_OFF_RESL 8'h0c
`define SAC_OFF_CVH 8'h10
`define SAC_OFF_CVL 8'h14
`define SAC_OFF_CFG 8'h18
`define SAC_OFF_PDL 8'h1c
`define SAC_OFF_PDM 8'h20
`define SAC_OFF_PDH 8'h24

// status_control_1 fields
`define SAC_SC1_CH_LSB 0
`define SAC_SC1_CONT_BIT 5
`define SAC_SC1_IRQEN_BIT 6
`define SAC_SC1_DONE_BIT 7
// status_control_2 fields
`define SAC_SC2_GT_BIT 4
`define SAC_SC2_CMPEN_BIT 5
`define SAC_SC2_HWT_BIT 6
`define SAC_SC2_ACTIVE_BIT 7
// config_reg fields
`define SAC_CFG_ICS_LSB 0
`define SAC_CFG_MODE_LSB 2
`define SAC_CFG_LSMP_BIT 4
`define SAC_CFG_DIV_LSB 5

// Reset values
`define SAC_RST_CH 5'h1f
`define SAC_RST_ICS 2'h0
`define SAC_RST_MODE 2'h0
`define SAC_RST_DIV 2'h0

// Channel code that switches the converter off
`define SAC_CH_OFF 5'h1f

// Conversion mode and clock source codes
`define SAC_MODE_8 2'h0
`define SAC_MODE_12 2'h1
`define SAC_MODE_10 2'h2
`define SAC_ICS_BUS 2'h0
`define SAC_ICS_BUS2 2'h1
`define SAC_ICS_ALT 2'h2
`define SAC_ICS_ASYNC 2'h3

// Sample phase in converter clocks: 3.5 and 23.5 rounded up
`define SAC_SAMPLE_SHORT 5'h04
`define SAC_SAMPLE_LONG 5'h18

// Number of analog pins
`define SAC_PIN_COUNT 24

`endif

// >>> pkg/sac_pkg.sv
`default_nettype none
package sac_pkg;

  // Conversion sequencer, Gray coded along idle-sample-convert-transfer
  typedef enum logic [1:0] {
    SAC_IDLE = 2'h0,
    SAC_SAMPLE = 2'h1,
    SAC_CONVERT = 2'h3,
    SAC_XFER = 2'h2
  } sac_state_e;

  // Pin isolation controls, one bit per analog pin
  typedef struct packed {
    logic [23:0] out_hiz;
    logic [23:0] input_dis;
    logic [23:0] pullup_dis;
  } sac_pin_ctl_s;

endpackage
`default_nettype wire

// >>> hdl/sac_sync.sv
`default_nettype none
module sac_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;

  // Two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/sac_conv_ctl.sv
`include "sac_cfg.svh"
`default_nettype none
// Overview of operation
// [RULE_01] Off in reset or channel all ones
// [RULE_02] Idle after completion is lowest power
// [RULE_03] Raw result twelve bits, nine in 8-bit
// [RULE_04] Round to ten or eight bits
// [RULE_05] Set done flag after result write
// [RULE_06] Compare enable checks every result
// [RULE_07] Four clock sources, bus after reset
// [RULE_08] Divide selected source by 1,2,4,8
// [RULE_09] Async clock runs on in low power
// [RULE_10] Disabled pins isolated, read as zero
// [RULE_11] Hardware trigger rising edge starts conversion
// [RULE_12] Edge ignored while conversion active
// [RULE_13] Continuous hardware mode: first edge only
// [RULE_14] Mode field selects 12, 10, 8 bits
// [RULE_15] Mode codes 00=8, 01=12, 10=10
// [RULE_16] Clock codes bus, bus/2, alt, async
// [RULE_17] Software write to control starts conversion
// [RULE_18] Continuous mode restarts until aborted
// [RULE_19] Interrupt only if enabled when set
// [RULE_20] High read pending blocks new result
// [RULE_21] Single compare-false: stop despite blocking
// [RULE_22] Other blocked transfers start another conversion
// [RULE_23] Software waits for completion before reading
// [RULE_24] Config or compare write aborts conversion
// [RULE_25] Synchronise trigger before edge detection
module sac_conv_ctl (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic hw_trigger_in,
  input wire logic cmp_in,
  input wire logic alt_clk_in,
  input wire logic async_clk_in,
  input wire logic stop_mode_in,
  input wire logic [`SAC_PIN_COUNT-1:0] pin_in,
  output logic [`SAC_PIN_COUNT-1:0] port_read_out,
  output sac_pkg::sac_pin_ctl_s pin_ctl_out,
  output logic [11:0] dac_code_out,
  output logic sample_out,
  output logic conv_power_out,
  output logic async_clk_run_out,
  output logic [4:0] channel_out,
  output logic conv_irq_out
);

  logic [`SAC_PIN_COUNT+3:0] sync_w;
  logic [`SAC_PIN_COUNT-1:0] pin_s;
  logic trig_s, cmp_s, alt_s, async_s;
  logic trig_prev_q, alt_prev_q, async_prev_q, half_q;
  logic cont_q, irq_en_q, hwt_en_q, cmp_en_q, cmp_gt_q, lsmp_q;
  logic [1:0] ics_q, mode_q, div_q;
  logic [3:0] cv_hi_q;
  logic [7:0] cv_lo_q;
  logic [15:0] result_q;
  logic done_q, hi_read_q;
  logic [2:0] div_cnt_q, div_max;
  logic [4:0] samp_cnt_q;
  logic [1:0] settle_q;
  logic settled_w;
  logic [3:0] bit_q;
  sac_pkg::sac_state_e state_q;
  logic setup_w, acc_w, wr_w, rd_w, map_hit;
  logic wr_sc1, wr_sc2, wr_cfg, wr_cvh, wr_cvl, rd_resh, rd_resl;
  logic src_tick, converter_clock_tick, wide_w, trig_rise, sw_start, hw_start, abort_w;
  logic [3:0] stop_bit;
  logic [10:0] r10_w;
  logic [8:0] r8_w;
  logic [11:0] value_w, cv_w;
  logic [15:0] diff_w;
  logic cond_w, block_w, xfer_ok, restart_w, done_set, done_clr;
  logic [31:0] rdata_w;

  // All pin-level inputs cross in one synchroniser bank
  sac_sync #(
    .WIDTH(`SAC_PIN_COUNT + 4)
  ) u_sync (
    .clk_in(mclk_in),
    .reset_in(reset_in),
    .d_in({pin_in, hw_trigger_in, cmp_in, alt_clk_in, async_clk_in}),
    .q_out(sync_w)
  );
  assign pin_s = sync_w[`SAC_PIN_COUNT+3:4];
  assign trig_s = sync_w[3]; // RULE_25
  assign cmp_s = sync_w[2];
  assign alt_s = sync_w[1];
  assign async_s = sync_w[0];

  // APB phases; one wait-free access after each setup
  assign setup_w = psel_in & ~penable_in;
  assign acc_w = psel_in & penable_in & pready_out;
  assign wr_w = acc_w & pwrite_in & ~pslverr_out;
  assign rd_w = acc_w & ~pwrite_in & ~pslverr_out;
  assign wr_sc1 = wr_w & (paddr_in == `SAC_OFF_SC1);
  assign wr_sc2 = wr_w & (paddr_in == `SAC_OFF_SC2);
  assign wr_cfg = wr_w & (paddr_in == `SAC_OFF_CFG);
  assign wr_cvh = wr_w & (paddr_in == `SAC_OFF_CVH);
  assign wr_cvl = wr_w & (paddr_in == `SAC_OFF_CVL);
  assign rd_resh = rd_w & (paddr_in == `SAC_OFF_RESH);
  assign rd_resl = rd_w & (paddr_in == `SAC_OFF_RESL);

  // Mode decode; the reserved code behaves as 8-bit
  assign wide_w = (mode_q == `SAC_MODE_12) || (mode_q == `SAC_MODE_10); // RULE_14 RULE_15
  assign stop_bit = wide_w ? 4'h0 : 4'h3; // RULE_03

  // Clock source pick, all as enables on the bus clock
  always_comb begin
    unique case (ics_q) // RULE_07 RULE_16
      `SAC_ICS_BUS: src_tick = 1'b1;
      `SAC_ICS_BUS2: src_tick = half_q;
      `SAC_ICS_ALT: src_tick = alt_s & ~alt_prev_q;
      `SAC_ICS_ASYNC: src_tick = async_s & ~async_prev_q;
    endcase
  end
  assign div_max = 3'((4'h1 << div_q) - 4'h1); // RULE_08
  assign converter_clock_tick = src_tick && (div_cnt_q == div_max);

  // Edge history and bus clock halving
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      half_q <= 1'b0;
      trig_prev_q <= 1'b0;
      alt_prev_q <= 1'b0;
      async_prev_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
      trig_prev_q <= trig_s;
      alt_prev_q <= alt_s;
      async_prev_q <= async_s;
    end
  end

  // Converter clock divider, held clear while idle
  always_ff @(posedge mclk_in) begin
    if (reset_in || state_q == sac_pkg::SAC_IDLE) begin
      div_cnt_q <= 3'h0;
    end else if (src_tick) begin
      div_cnt_q <= (div_cnt_q == div_max) ? 3'h0 : 3'(div_cnt_q + 3'h1); // RULE_08
    end
  end

  // Start and abort sources
  assign trig_rise = trig_s & ~trig_prev_q; // RULE_25
  assign sw_start = wr_sc1 && (pwdata_in[4:0] != `SAC_CH_OFF) && !hwt_en_q; // RULE_17 RULE_01
  // Only an idle converter hears the trigger, so continuous runs see one edge
  assign hw_start = hwt_en_q && trig_rise && (state_q == sac_pkg::SAC_IDLE)
                    && (channel_out != `SAC_CH_OFF); // RULE_11 RULE_12 RULE_13
  // Stop mode kills the run unless the async clock drives it
  assign abort_w = wr_sc1 || wr_sc2 || wr_cfg || wr_cvh || wr_cvl
                   || (stop_mode_in && ics_q != `SAC_ICS_ASYNC); // RULE_24 RULE_09

  // Rounding of the raw code, saturating at full scale
  assign r10_w = 11'({1'b0, dac_code_out[11:2]} + {10'h000, dac_code_out[1]}); // RULE_04
  assign r8_w = 9'({1'b0, dac_code_out[11:4]} + {8'h00, dac_code_out[3]}); // RULE_04
  always_comb begin
    unique case (mode_q)
      `SAC_MODE_12: value_w = dac_code_out;
      `SAC_MODE_10: value_w = r10_w[10] ? 12'h3ff : {2'h0, r10_w[9:0]};
      default: value_w = r8_w[8] ? 12'h0ff : {4'h0, r8_w[7:0]};
    endcase
  end

  // Compare against the limit; difference replaces the result
  assign cv_w = wide_w ? {cv_hi_q, cv_lo_q} : {4'h0, cv_lo_q};
  assign diff_w = 16'({4'h0, value_w} - {4'h0, cv_w}); // RULE_06
  assign cond_w = cmp_gt_q ? (value_w >= cv_w) : (value_w < cv_w); // RULE_06

  // Transfer decision made in the transfer state
  assign block_w = wide_w && hi_read_q; // RULE_20
  assign xfer_ok = !block_w && (!cmp_en_q || cond_w); // RULE_20 RULE_06
  always_comb begin
    if (cmp_en_q && !cond_w && !cont_q) begin
      restart_w = 1'b0; // RULE_21
    end else if (block_w) begin
      restart_w = 1'b1; // RULE_22
    end else begin
      restart_w = cont_q; // RULE_18
    end
  end
  assign done_set = (state_q == sac_pkg::SAC_XFER) && xfer_ok && !abort_w;
  assign done_clr = wr_sc1 || rd_resl;

  // Comparator crosses two flops; a decision waits until it sees the new code
  always_ff @(posedge mclk_in) begin
    if (reset_in || state_q != sac_pkg::SAC_CONVERT) begin
      settle_q <= 2'h0;
    end else if (converter_clock_tick && settled_w) begin
      settle_q <= 2'h0;
    end else if (!settled_w) begin
      settle_q <= 2'(settle_q + 2'h1);
    end
  end
  assign settled_w = (settle_q == 2'h2); // RULE_03

  // Conversion sequencer
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q <= sac_pkg::SAC_IDLE; // RULE_01
      samp_cnt_q <= 5'h00;
      bit_q <= 4'h0;
      dac_code_out <= 12'h000;
    end else if (abort_w && !sw_start) begin
      state_q <= sac_pkg::SAC_IDLE; // RULE_24
    end else if (sw_start || hw_start) begin
      state_q <= sac_pkg::SAC_SAMPLE; // RULE_17 RULE_11
      samp_cnt_q <= lsmp_q ? `SAC_SAMPLE_LONG : `SAC_SAMPLE_SHORT;
    end else begin
      unique case (state_q)
        sac_pkg::SAC_IDLE: begin
          state_q <= sac_pkg::SAC_IDLE; // RULE_02
        end
        sac_pkg::SAC_SAMPLE: begin
          if (converter_clock_tick) begin
            if (samp_cnt_q == 5'h01) begin
              state_q <= sac_pkg::SAC_CONVERT;
              dac_code_out <= 12'h800;
              bit_q <= 4'hb;
            end else begin
              samp_cnt_q <= 5'(samp_cnt_q - 5'h01);
            end
          end
        end
        sac_pkg::SAC_CONVERT: begin
          // Keep the trial bit only if the input is at or above it
          if (converter_clock_tick && settled_w) begin
            dac_code_out[bit_q] <= cmp_s; // RULE_03
            if (bit_q == stop_bit) begin
              state_q <= sac_pkg::SAC_XFER;
            end else begin
              dac_code_out[bit_q - 4'h1] <= 1'b1;
              bit_q <= 4'(bit_q - 4'h1);
            end
          end
        end
        sac_pkg::SAC_XFER: begin
          if (restart_w) begin
            state_q <= sac_pkg::SAC_SAMPLE; // RULE_18 RULE_22
            samp_cnt_q <= lsmp_q ? `SAC_SAMPLE_LONG : `SAC_SAMPLE_SHORT;
          end else begin
            state_q <= sac_pkg::SAC_IDLE; // RULE_02 RULE_21
          end
        end
      endcase
    end
  end

  // Result registers; aborts leave them untouched
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      result_q <= 16'h0000;
    end else if (done_set) begin
      if (cmp_en_q) begin
        result_q <= wide_w ? diff_w : {8'h00, diff_w[7:0]}; // RULE_06
      end else begin
        result_q <= {4'h0, value_w}; // RULE_04
      end
    end
  end

  // Done flag and interrupt; a set in the clear cycle wins
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      done_q <= 1'b0;
      conv_irq_out <= 1'b0;
    end else begin
      if (done_set) begin
        done_q <= 1'b1; // RULE_05
      end else if (done_clr) begin
        done_q <= 1'b0;
      end
      if (done_set && irq_en_q) begin
        conv_irq_out <= 1'b1; // RULE_19
      end else if (done_clr || !irq_en_q) begin
        conv_irq_out <= 1'b0;
      end
    end
  end

  // Read interlock: high byte read arms in 12- and 10-bit modes, low byte read releases
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hi_read_q <= 1'b0;
    end else if (rd_resl) begin
      hi_read_q <= 1'b0;
    end else if (rd_resh && wide_w) begin
      hi_read_q <= 1'b1; // RULE_20
    end
  end

  // Control and configuration registers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      channel_out <= `SAC_RST_CH; // RULE_01
      cont_q <= 1'b0;
      irq_en_q <= 1'b0;
      hwt_en_q <= 1'b0;
      cmp_en_q <= 1'b0;
      cmp_gt_q <= 1'b0;
      ics_q <= `SAC_RST_ICS; // RULE_07
      mode_q <= `SAC_RST_MODE;
      div_q <= `SAC_RST_DIV;
      lsmp_q <= 1'b0;
      cv_hi_q <= 4'h0;
      cv_lo_q <= 8'h00;
    end else begin
      if (wr_sc1) begin
        channel_out <= pwdata_in[`SAC_SC1_CH_LSB +: 5];
        cont_q <= pwdata_in[`SAC_SC1_CONT_BIT];
        irq_en_q <= pwdata_in[`SAC_SC1_IRQEN_BIT];
      end
      if (wr_sc2) begin
        hwt_en_q <= pwdata_in[`SAC_SC2_HWT_BIT];
        cmp_en_q <= pwdata_in[`SAC_SC2_CMPEN_BIT];
        cmp_gt_q <= pwdata_in[`SAC_SC2_GT_BIT];
      end
      if (wr_cfg) begin
        ics_q <= pwdata_in[`SAC_CFG_ICS_LSB +: 2];
        mode_q <= pwdata_in[`SAC_CFG_MODE_LSB +: 2];
        lsmp_q <= pwdata_in[`SAC_CFG_LSMP_BIT];
        div_q <= pwdata_in[`SAC_CFG_DIV_LSB +: 2];
      end
      if (wr_cvh) begin
        cv_hi_q <= pwdata_in[3:0];
      end
      if (wr_cvl) begin
        cv_lo_q <= pwdata_in[7:0];
      end
    end
  end

  // Pin isolation; all three controls follow one disable bit
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pin_ctl_out <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_w && paddr_in == 8'(`SAC_OFF_PDL + 8'(4 * i))) begin
          pin_ctl_out.out_hiz[8*i +: 8] <= pwdata_in[7:0]; // RULE_10
          pin_ctl_out.input_dis[8*i +: 8] <= pwdata_in[7:0];
          pin_ctl_out.pullup_dis[8*i +: 8] <= pwdata_in[7:0];
        end
      end
    end
  end

  // Port reads of isolated pins return zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      port_read_out <= '0;
    end else begin
      port_read_out <= pin_s & ~pin_ctl_out.input_dis; // RULE_10
    end
  end

  // Analog-side status outputs
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sample_out <= 1'b0;
      conv_power_out <= 1'b0;
      async_clk_run_out <= 1'b0;
    end else begin
      sample_out <= (state_q == sac_pkg::SAC_SAMPLE);
      conv_power_out <= (state_q != sac_pkg::SAC_IDLE); // RULE_02 RULE_01
      // Kept on whatever the low-power mode while a run uses it
      async_clk_run_out <= (ics_q == `SAC_ICS_ASYNC)
                           && (state_q != sac_pkg::SAC_IDLE); // RULE_09
    end
  end

  // Read mux, evaluated in the setup phase
  always_comb begin
    rdata_w = 32'h0000_0000;
    map_hit = 1'b1;
    unique case (paddr_in)
      `SAC_OFF_SC1: rdata_w[7:0] = {done_q, irq_en_q, cont_q, channel_out};
      `SAC_OFF_SC2: rdata_w[7:0] = {state_q != sac_pkg::SAC_IDLE, hwt_en_q, cmp_en_q,
                                    cmp_gt_q, 4'h0};
      `SAC_OFF_RESH: rdata_w[7:0] = result_q[15:8];
      `SAC_OFF_RESL: rdata_w[7:0] = result_q[7:0];
      `SAC_OFF_CVH: rdata_w[3:0] = cv_hi_q;
      `SAC_OFF_CVL: rdata_w[7:0] = cv_lo_q;
      `SAC_OFF_CFG: rdata_w[6:0] = {div_q, lsmp_q, mode_q, ics_q};
      `SAC_OFF_PDL: rdata_w[7:0] = pin_ctl_out.out_hiz[7:0];
      `SAC_OFF_PDM: rdata_w[7:0] = pin_ctl_out.out_hiz[15:8];
      `SAC_OFF_PDH: rdata_w[7:0] = pin_ctl_out.out_hiz[23:16];
      default: map_hit = 1'b0;
    endcase
  end

  // APB answer registered one cycle after setup
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= setup_w;
      pslverr_out <= setup_w && !map_hit;
      if (setup_w) begin
        prdata_out <= (pwrite_in || !map_hit) ? 32'h0000_0000 : rdata_w;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verif/sac_conv_ctl_props.sv
`default_nettype none
module sac_conv_ctl_chk (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [4:0] channel_out,
  input wire logic conv_power_out,
  input wire logic sample_out,
  input wire logic async_clk_run_out,
  input wire logic conv_irq_out,
  input wire logic [23:0] port_read_out,
  input wire sac_pkg::sac_pin_ctl_s pin_ctl_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  // Pin controls must be stable a while, since the port path lags
  sequence s_dis_steady;
    $stable(pin_ctl_out.input_dis) [*4];
  endsequence
  a_ready_follows: assert property ((psel_in && !penable_in) |=> pready_out)
    else $error("no ready after setup");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_reset_off: assert property (disable iff (1'b0) reset_in |=>
    (channel_out == 5'h1f && !conv_power_out && !conv_irq_out))
    else $error("converter active after reset");
  a_off_no_power: assert property ((channel_out == 5'h1f &&
    $past(channel_out) == 5'h1f) |-> !conv_power_out)
    else $error("powered with channel off");
  a_sample_powered: assert property (sample_out |-> conv_power_out)
    else $error("sampling while idle");
  a_async_powered: assert property (async_clk_run_out |-> conv_power_out)
    else $error("async clock runs while idle");
  a_irq_at_end: assert property ($rose(conv_irq_out) |-> $past(conv_power_out))
    else $error("interrupt without conversion");
  a_pins_alike: assert property (pin_ctl_out.out_hiz == pin_ctl_out.input_dis &&
    pin_ctl_out.pullup_dis == pin_ctl_out.input_dis)
    else $error("pin controls differ");
  a_port_zero: assert property (s_dis_steady |->
    (port_read_out & pin_ctl_out.input_dis) == 24'h000000)
    else $error("disabled pin reads nonzero");
  c_sample: cover property ($rose(sample_out));
  c_irq: cover property ($rose(conv_irq_out));
  c_err: cover property (pslverr_out);
endmodule
bind sac_conv_ctl sac_conv_ctl_chk u_chk (
  .mclk_in(mclk_in),
  .reset_in(reset_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .channel_out(channel_out),
  .conv_power_out(conv_power_out),
  .sample_out(sample_out),
  .async_clk_run_out(async_clk_run_out),
  .conv_irq_out(conv_irq_out),
  .port_read_out(port_read_out),
  .pin_ctl_out(pin_ctl_out)
);
`default_nettype wire

// >>> verif/sac_analog_model.sv
`default_nettype none
module sac_analog_model (
  input wire logic mclk_in,
  input wire logic [11:0] level_in,
  input wire logic [11:0] dac_code_in,
  output logic cmp_out,
  output logic alt_clk_out,
  output logic async_clk_out,
  output logic hw_trigger_out,
  output logic [23:0] pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ideal comparator: input at or above the trial code
  assign cmp_out = (level_in >= dac_code_in);
  assign pin_out = 24'hffffff;
  initial begin
    alt_clk_out = 1'b0;
    async_clk_out = 1'b0;
    hw_trigger_out = 1'b0;
  end
  // Free sources slower than half the bus rate so edges are caught
  always #15 alt_clk_out = ~alt_clk_out;
  always #20 async_clk_out = ~async_clk_out;
  // Trigger pulse held several cycles, well past the synchroniser
  task automatic pulse;
    @(posedge mclk_in) hw_trigger_out <= 1'b1;
    repeat (3) @(posedge mclk_in);
    hw_trigger_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`include "sac_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, perr, pready, e;
  logic trig, cmpv, altc, asyc, pwr_on, smp, arun, irq;
  logic stop = 0;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, prd, q;
  logic [11:0] lvl = 0, dac;
  logic [23:0] pins, port_rd;
  logic [4:0] chn;
  logic [15:0] r;
  sac_pkg::sac_pin_ctl_s pc;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  logic [7:0] cfgs [4] = '{8'h04, 8'h29, 8'h42, 8'h67};
  logic [11:0] lvls [4] = '{12'ha5c, 12'ha5f, 12'h5bf, 12'h3a1};
  logic [15:0] exps [4] = '{16'h0a5c, 16'h0298, 16'h005c, 16'h03a1};
  always #5 clk = ~clk;
  sac_conv_ctl dut (
    .mclk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(pready), .pslverr_out(perr), .hw_trigger_in(trig),
    .cmp_in(cmpv), .alt_clk_in(altc), .async_clk_in(asyc),
    .stop_mode_in(stop), .pin_in(pins), .port_read_out(port_rd),
    .pin_ctl_out(pc), .dac_code_out(dac), .sample_out(smp),
    .conv_power_out(pwr_on), .async_clk_run_out(arun),
    .channel_out(chn), .conv_irq_out(irq)
  );
  sac_analog_model am (
    .mclk_in(clk), .level_in(lvl), .dac_code_in(dac), .cmp_out(cmpv),
    .alt_clk_out(altc), .async_clk_out(asyc), .hw_trigger_out(trig),
    .pin_out(pins)
  );
  // One APB transfer; idle cycle after so psel never toggles twice per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk) pen <= 1'b1;
    // Only pready or the bench timeout ends this wait
    do @(posedge clk); while (pready !== 1'b1);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s exp %h got %h", s, x, g);
    end
  endtask
  // Polls status only; result registers stay untouched meanwhile
  task automatic wait_done;
    int n;
    n = 0;
    q = 0;
    while (q[7] !== 1'b1 && n++ < 600) apb(1'b0, `SAC_OFF_SC1, 0);
  endtask
  task automatic rd_res;
    apb(1'b0, `SAC_OFF_RESH, 0);
    r[15:8] = q[7:0];
    apb(1'b0, `SAC_OFF_RESL, 0);
    r[7:0] = q[7:0];
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far above the slowest async conversion run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `SAC_OFF_SC1, 0);
    chk("sc1", 32'h1f, q);
    apb(1'b0, `SAC_OFF_CFG, 0);
    chk("cfg", 32'h0, q);
    apb(1'b0, 8'h28, 0);
    chk("slverr", 32'h1, {31'h0, e});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `SAC_OFF_CFG, {24'h0, cfgs[i]});
      lvl <= lvls[i];
      apb(1'b1, `SAC_OFF_SC1, i[0] ? 32'h43 : 32'h03);
      repeat (8) @(posedge clk);
      chk("async_run", {31'h0, i == 3}, {31'h0, arun});
      // Stop mode only on the async run, which must carry on through it
      stop <= (i == 3);
      wait_done();
      chk("done", 32'h1, {31'h0, q[7]});
      chk("irq", {31'h0, i[0]}, {31'h0, irq});
      rd_res();
      chk("result", {16'h0, exps[i]}, {16'h0, r});
    end
    stop <= 1'b0;
    $display("test modes done");
    apb(1'b1, `SAC_OFF_CFG, 32'h04);
    apb(1'b1, `SAC_OFF_SC2, 32'h40);
    apb(1'b1, `SAC_OFF_SC1, 32'h03);
    chk("hw_nostart", 32'h0, {31'h0, pwr_on});
    apb(1'b0, `SAC_OFF_RESH, 0);
    lvl <= 12'h123;
    am.pulse();
    repeat (50) @(posedge clk);
    apb(1'b0, `SAC_OFF_SC1, 0);
    chk("blocked_done", 32'h0, {31'h0, q[7]});
    chk("restarted", 32'h1, {31'h0, pwr_on});
    apb(1'b0, `SAC_OFF_RESL, 0);
    chk("old_low", 32'ha1, q);
    wait_done();
    rd_res();
    chk("hw_result", 32'h0123, {16'h0, r});
    $display("test interlock done");
    am.pulse();
    repeat (6) @(posedge clk);
    am.pulse();
    wait_done();
    apb(1'b0, `SAC_OFF_RESL, 0);
    repeat (60) @(posedge clk);
    chk("idle", 32'h0, {31'h0, pwr_on});
    apb(1'b1, `SAC_OFF_SC2, 32'h0);
    apb(1'b1, `SAC_OFF_SC1, 32'h03);
    lvl <= 12'h777;
    repeat (4) @(posedge clk);
    apb(1'b1, `SAC_OFF_CVL, 32'h0);
    repeat (60) @(posedge clk);
    apb(1'b0, `SAC_OFF_SC1, 0);
    chk("abort_done", 32'h0, {31'h0, q[7]});
    rd_res();
    chk("abort_keep", 32'h0123, {16'h0, r});
    // Stop mode on the bus clock kills the run
    apb(1'b1, `SAC_OFF_SC1, 32'h03);
    stop <= 1'b1;
    repeat (4) @(posedge clk);
    chk("stop_abort", 32'h0, {31'h0, pwr_on});
    stop <= 1'b0;
    $display("test abort done");
    apb(1'b1, `SAC_OFF_SC1, 32'h23);
    wait_done();
    apb(1'b0, `SAC_OFF_RESL, 0);
    wait_done();
    chk("cont_done", 32'h1, {31'h0, q[7]});
    apb(1'b1, `SAC_OFF_SC1, 32'h1f);
    repeat (3) @(posedge clk);
    chk("off", 32'h0, {31'h0, pwr_on});
    $display("test continuous done");
    apb(1'b1, `SAC_OFF_CVH, 32'h08);
    apb(1'b1, `SAC_OFF_CVL, 32'h00);
    apb(1'b1, `SAC_OFF_SC2, 32'h30);
    lvl <= 12'ha5c;
    apb(1'b1, `SAC_OFF_SC1, 32'h03);
    wait_done();
    rd_res();
    chk("cmp_diff", 32'h025c, {16'h0, r});
    // Arm the interlock so a false compare must still stop the run
    apb(1'b0, `SAC_OFF_RESH, 0);
    lvl <= 12'h400;
    apb(1'b1, `SAC_OFF_SC1, 32'h03);
    repeat (80) @(posedge clk);
    apb(1'b0, `SAC_OFF_SC1, 0);
    chk("cmp_false", 32'h0, {31'h0, q[7]});
    chk("cmp_stop", 32'h0, {31'h0, pwr_on});
    $display("test compare done");
    apb(1'b1, `SAC_OFF_PDL, 32'hff);
    apb(1'b1, `SAC_OFF_PDM, 32'h0f);
    repeat (5) @(posedge clk);
    chk("port", 32'hfff000, {8'h0, port_rd});
    chk("hiz", 32'h000fff, {8'h0, pc.out_hiz});
    $display("test pins done");
    end_sim();
  end
endmodule
`default_nettype wire
